// ---- verilog/ectdi_pkg.sv ----
// Package: constants, types and check-bit helper for the cache controller
package ectdi_pkg;
  localparam int ADR_W = 29;
  localparam int TAG_W = 17;
  localparam int DATA_W = 128;
  localparam int LW_N = 4;
  localparam int LW_W = 32;
  localparam int ECC_W = 7;
  localparam int CHK_W = 28;
  localparam int CTL_W = 4;
  localparam int SIZE_W = 4;
  localparam int CLEN_W = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int REQ_W = 2 + ADR_W + DATA_W;
  localparam int CTL_V = 3;
  localparam int CTL_S = 2;
  localparam int CTL_D = 1;
  localparam int XNOR_A = 3;
  localparam int XNOR_B = 2;
  localparam logic [TAG_W-1:0] TAG_ALL = 17'h1ffff;
  localparam logic OE_N_RST = 1'b1;
  localparam logic [CLEN_W-1:0] CNT_RST = 4'h0;
  // One data mask per check bit, c0 first
  localparam logic [LW_W-1:0] ECC_MASK [ECC_W] = '{
    32'h56aa_ad5b, 32'h9b33_366d, 32'he3c3_c78e, 32'h03fc_07f0,
    32'h03ff_f800, 32'hfc00_0000, 32'hffff_ffff};

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_TAG = 6'h02,
    ST_DATA = 6'h04,
    ST_DIRTY = 6'h08,
    ST_EXT = 6'h10,
    ST_HOLD = 6'h20
  } ectdi_state_t;

  function automatic logic [ECC_W-1:0] ecc_bits(input logic [LW_W-1:0] d);
    logic [ECC_W-1:0] c;
    c = '0;
    for (int k = 0; k < ECC_W; k++)
    begin
      c[k] = ^(d & ECC_MASK[k]);
    end
    c[XNOR_A] = ~c[XNOR_A];
    c[XNOR_B] = ~c[XNOR_B];
    return c;
  endfunction
endpackage

// ---- verilog/ectdi_fifo.sv ----
// Request FIFO between the core and the cache sequencer
`timescale 1ns/10ps
`default_nettype none
module ectdi_fifo
  #(parameter int W = 8,
    parameter int D = 8)
  (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
  );
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] FULL = CW'(D);
  localparam logic [PW-1:0] LAST = PW'(D - 1);
  logic [W-1:0] mem_reg [D];
  logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic rdy_reg, rdy_next;
  logic push, pop;

  always_comb
  begin
    push = in_valid && rdy_reg;
    pop = out_valid && out_ready;
    wr_next = wr_reg;
    rd_next = rd_reg;
    if (push)
      wr_next = (wr_reg == LAST) ? '0 : wr_reg + 1'b1;
    if (pop)
      rd_next = (rd_reg == LAST) ? '0 : rd_reg + 1'b1;
    cnt_next = cnt_reg + CW'(push) - CW'(pop);
    // Registered ready keeps the core path short
    rdy_next = cnt_next != FULL;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b0;
    end
    else
    begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      rdy_reg <= rdy_next;
    end
    if (push)
      mem_reg[wr_reg] <= in_data;
  end

  assign in_ready = rdy_reg;
  assign out_valid = cnt_reg != '0;
  assign out_data = mem_reg[rd_reg];
endmodule // ectdi_fifo
`default_nettype wire

// ---- verilog/ectdi_top.sv ----
// External second-level cache tag and data RAM sequencer
`timescale 1ns/10ps
`default_nettype none
module ectdi_top
  import ectdi_pkg::*;
  (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_special,
  input wire logic [ADR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic cache_enable_bit,
  input wire logic ecc_select_bit,
  input wire logic enable_style_bit,
  input wire logic [SIZE_W-1:0] cache_size_field,
  input wire logic [CLEN_W-1:0] cycle_len,
  output logic rsp_valid,
  output logic rsp_local,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic hard_error,
  output logic data_error,
  input wire logic [ADR_W-1:0] adr_in,
  output logic [ADR_W-1:0] adr_out,
  output logic adr_oe_n,
  output logic tag_equal_n,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  input wire logic [CHK_W-1:0] check_in,
  output logic [CHK_W-1:0] check_out,
  output logic data_oe_n,
  input wire logic ext_data_drive_enable_n,
  input wire logic [TAG_W-1:0] tag_address_in,
  input wire logic tag_address_parity_in,
  output logic tag_ram_enable,
  output logic tag_ctl_write_enable,
  input wire logic [CTL_W-1:0] tag_ctl_in,
  output logic [CTL_W-1:0] tag_ctl_out,
  output logic tag_ctl_oe_n,
  output logic data_ram_enable,
  output logic data_ram_write_enable,
  input wire logic cache_hold_request,
  output logic cache_hold_grant,
  output logic ext_cycle_req,
  input wire logic ext_cycle_done
  );
  localparam int SW = ADR_W + TAG_W + 1 + CTL_W + DATA_W + CHK_W + 3;
  logic [SW-1:0] meta_reg, sync_reg;
  logic [ADR_W-1:0] s_adr;
  logic [TAG_W-1:0] s_tag, tag_mask;
  logic [CTL_W-1:0] s_ctl;
  logic [DATA_W-1:0] s_data;
  logic [CHK_W-1:0] s_chk, gen_chk;
  logic s_tpar, s_doe_n, s_hold, s_done;
  logic fifo_valid, fifo_ready;
  logic [REQ_W-1:0] fifo_data;
  logic [LW_N-1:0] rd_bad;
  logic eq_comb, tag_hit, tag_par_bad, ctl_par_bad, hit, last;
  ectdi_state_t state_reg, state_next;
  logic [CLEN_W-1:0] cnt_reg, cnt_next;
  logic op_wr_reg, op_wr_next, op_spec_reg, op_spec_next;
  logic dirty_reg, dirty_next;
  logic [ADR_W-1:0] adr_out_reg, adr_out_next;
  logic adr_oe_n_reg, adr_oe_n_next, teq_n_reg, teq_n_next;
  logic [DATA_W-1:0] dout_reg, dout_next, rdata_reg, rdata_next;
  logic [CHK_W-1:0] cout_reg, cout_next;
  logic doe_n_reg, doe_n_next, tren_reg, tren_next;
  logic ctlwe_reg, ctlwe_next, ctloe_n_reg, ctloe_n_next;
  logic [CTL_W-1:0] ctl_reg, ctl_next;
  logic den_reg, den_next, dwe_reg, dwe_next;
  logic grant_reg, grant_next, ext_reg, ext_next;
  logic rv_reg, rv_next, rl_reg, rl_next;
  logic herr_reg, herr_next, derr_reg, derr_next;
  logic armed_reg, armed_next;

  ectdi_fifo #(.W(REQ_W), .D(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data({req_write, req_special, req_addr, req_wdata}),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );

  // All pin inputs pass two flops before use
  always_ff @(posedge core_clk)
  begin
    meta_reg <= {adr_in, tag_address_in, tag_address_parity_in, tag_ctl_in,
      data_in, check_in, ext_data_drive_enable_n, cache_hold_request,
      ext_cycle_done};
    sync_reg <= meta_reg;
  end
  assign {s_adr, s_tag, s_tpar, s_ctl, s_data, s_chk, s_doe_n, s_hold,
    s_done} = sync_reg;

  assign tag_mask = TAG_ALL << cache_size_field;
  assign eq_comb = ((s_adr[ADR_W-1 -: TAG_W] ^ s_tag) & tag_mask) == '0;
  assign tag_hit = ((adr_out_reg[ADR_W-1 -: TAG_W] ^ s_tag) & tag_mask)
    == '0;
  assign tag_par_bad = ^{s_tag & tag_mask, s_tpar};
  assign ctl_par_bad = ^s_ctl;
  // Invalid, private, dirty, shared from the three state lines
  assign hit = cache_enable_bit && tag_hit && s_ctl[CTL_V] && !op_spec_reg
    && !(op_wr_reg && s_ctl[CTL_S]);
  assign last = cnt_reg == '0;
  assign fifo_ready = (state_reg == ST_IDLE) && !s_hold;

  genvar gi;
  generate
    for (gi = 0; gi < LW_N; gi++)
    begin : g_lw
      // Parity mode keeps only bit 0 of each lane
      assign gen_chk[gi*ECC_W +: ECC_W] = ecc_select_bit ?
        ecc_bits(fifo_data[gi*LW_W +: LW_W]) :
        {{(ECC_W-1){1'b0}}, ^fifo_data[gi*LW_W +: LW_W]};
      assign rd_bad[gi] = ecc_select_bit ?
        (s_chk[gi*ECC_W +: ECC_W] != ecc_bits(s_data[gi*LW_W +: LW_W])) :
        (s_chk[gi*ECC_W] != ^s_data[gi*LW_W +: LW_W]);
    end
  endgenerate

  always_comb
  begin
    state_next = state_reg;
    cnt_next = last ? cnt_reg : cnt_reg - 1'b1;
    op_wr_next = op_wr_reg;
    op_spec_next = op_spec_reg;
    dirty_next = dirty_reg;
    adr_out_next = adr_out_reg;
    adr_oe_n_next = adr_oe_n_reg;
    dout_next = dout_reg;
    cout_next = cout_reg;
    rdata_next = rdata_reg;
    doe_n_next = doe_n_reg;
    tren_next = 1'b0;
    ctlwe_next = 1'b0;
    ctloe_n_next = OE_N_RST;
    ctl_next = ctl_reg;
    den_next = den_reg;
    dwe_next = dwe_reg;
    grant_next = grant_reg;
    ext_next = ext_reg;
    rv_next = 1'b0;
    rl_next = rl_reg;
    herr_next = 1'b0;
    derr_next = 1'b0;
    armed_next = 1'b0;
    teq_n_next = !(adr_oe_n_reg && eq_comb);
    unique case (state_reg)
      ST_IDLE:
      begin
        adr_oe_n_next = 1'b0;
        if (s_hold)
        begin
          // Idle means no cycle left to finish
          adr_oe_n_next = OE_N_RST;
          grant_next = 1'b1;
          state_next = ST_HOLD;
        end
        else if (fifo_valid)
        begin
          op_wr_next = fifo_data[REQ_W-1];
          op_spec_next = fifo_data[REQ_W-2];
          adr_out_next = fifo_data[DATA_W +: ADR_W];
          dout_next = fifo_data[DATA_W-1:0];
          cout_next = gen_chk;
          cnt_next = cycle_len;
          if (!cache_enable_bit)
          begin
            ext_next = 1'b1;
            state_next = ST_EXT;
          end
          else
          begin
            tren_next = !enable_style_bit;
            state_next = ST_TAG;
          end
        end
      end
      ST_TAG:
      begin
        tren_next = !last;
        if (last)
        begin
          dirty_next = s_ctl[CTL_D];
          cnt_next = cycle_len;
          if (tag_par_bad || ctl_par_bad)
          begin
            herr_next = 1'b1;
            rv_next = 1'b1;
            rl_next = 1'b0;
            state_next = ST_IDLE;
          end
          else if (hit)
          begin
            den_next = 1'b1;
            dwe_next = op_wr_reg;
            doe_n_next = !op_wr_reg;
            state_next = ST_DATA;
          end
          else
          begin
            ext_next = 1'b1;
            state_next = ST_EXT;
          end
        end
      end
      ST_DATA:
      begin
        if (last)
        begin
          den_next = 1'b0;
          dwe_next = 1'b0;
          doe_n_next = OE_N_RST;
          cnt_next = cycle_len;
          if (op_wr_reg && !dirty_reg)
          begin
            // Mark block dirty: valid, private, dirty
            ctl_next = {1'b1, 1'b0, 1'b1, ^{1'b1, 1'b0, 1'b1}};
            ctloe_n_next = 1'b0;
            ctlwe_next = 1'b1;
            tren_next = 1'b1;
            state_next = ST_DIRTY;
          end
          else
          begin
            rdata_next = s_data;
            derr_next = !op_wr_reg && (|rd_bad);
            rv_next = 1'b1;
            rl_next = 1'b1;
            state_next = ST_IDLE;
          end
        end
      end
      ST_DIRTY:
      begin
        ctloe_n_next = last;
        ctlwe_next = !last;
        tren_next = !last;
        if (last)
        begin
          rv_next = 1'b1;
          rl_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      ST_EXT:
      begin
        // Hold may arrive mid-cycle; buses follow it
        grant_next = s_hold;
        adr_oe_n_next = s_hold;
        doe_n_next = s_hold || !(op_wr_reg && !s_doe_n);
        // Done must read low once; a stale synced done ends nothing
        armed_next = armed_reg || !s_done;
        if (s_done && armed_reg)
        begin
          ext_next = 1'b0;
          doe_n_next = OE_N_RST;
          rdata_next = s_data;
          rv_next = 1'b1;
          rl_next = 1'b0;
          state_next = ST_IDLE;
        end
      end
      ST_HOLD:
      begin
        if (!s_hold)
        begin
          grant_next = 1'b0;
          adr_oe_n_next = 1'b0;
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= CNT_RST;
      op_wr_reg <= 1'b0;
      op_spec_reg <= 1'b0;
      dirty_reg <= 1'b0;
      adr_out_reg <= '0;
      adr_oe_n_reg <= OE_N_RST;
      teq_n_reg <= !eq_comb;
      dout_reg <= '0;
      cout_reg <= '0;
      rdata_reg <= '0;
      doe_n_reg <= OE_N_RST;
      tren_reg <= 1'b0;
      ctlwe_reg <= 1'b0;
      ctloe_n_reg <= OE_N_RST;
      ctl_reg <= '0;
      den_reg <= 1'b0;
      dwe_reg <= 1'b0;
      grant_reg <= 1'b0;
      ext_reg <= 1'b0;
      rv_reg <= 1'b0;
      rl_reg <= 1'b0;
      herr_reg <= 1'b0;
      derr_reg <= 1'b0;
      armed_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      op_wr_reg <= op_wr_next;
      op_spec_reg <= op_spec_next;
      dirty_reg <= dirty_next;
      adr_out_reg <= adr_out_next;
      adr_oe_n_reg <= adr_oe_n_next;
      teq_n_reg <= teq_n_next;
      dout_reg <= dout_next;
      cout_reg <= cout_next;
      rdata_reg <= rdata_next;
      doe_n_reg <= doe_n_next;
      tren_reg <= tren_next;
      ctlwe_reg <= ctlwe_next;
      ctloe_n_reg <= ctloe_n_next;
      ctl_reg <= ctl_next;
      den_reg <= den_next;
      dwe_reg <= dwe_next;
      grant_reg <= grant_next;
      ext_reg <= ext_next;
      rv_reg <= rv_next;
      rl_reg <= rl_next;
      herr_reg <= herr_next;
      derr_reg <= derr_next;
      armed_reg <= armed_next;
    end
  end

  assign adr_out = adr_out_reg;
  assign adr_oe_n = adr_oe_n_reg;
  assign tag_equal_n = teq_n_reg;
  assign data_out = dout_reg;
  assign check_out = cout_reg;
  assign data_oe_n = doe_n_reg;
  assign tag_ram_enable = tren_reg;
  assign tag_ctl_write_enable = ctlwe_reg;
  assign tag_ctl_out = ctl_reg;
  assign tag_ctl_oe_n = ctloe_n_reg;
  assign data_ram_enable = den_reg;
  assign data_ram_write_enable = dwe_reg;
  assign cache_hold_grant = grant_reg;
  assign ext_cycle_req = ext_reg;
  assign rsp_valid = rv_reg;
  assign rsp_local = rl_reg;
  assign rsp_rdata = rdata_reg;
  assign hard_error = herr_reg;
  assign data_error = derr_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_reset_release: assert property (disable iff (1'b0) rst |=>
    adr_oe_n_reg && doe_n_reg && !tren_reg)
    else $error("buses driven after reset");
  a_tag_compare: assert property (adr_oe_n_reg |=>
    teq_n_reg == !$past(eq_comb))
    else $error("tag equal wrong while released");
  a_write_drive: assert property ((state_reg == ST_DATA) &&
    op_wr_reg |-> !doe_n_reg && dwe_reg)
    else $error("fast write not driving data");
  a_hit_local: assert property ((state_reg == ST_TAG) && last &&
    !tag_par_bad && !ctl_par_bad |=> (state_reg == ST_DATA) == $past(hit))
    else $error("hit decision wrong");
  a_disabled_ext: assert property (fifo_ready && fifo_valid &&
    !cache_enable_bit |=> state_reg == ST_EXT)
    else $error("disabled cache cycle kept local");
  a_phase_len: assert property ($rose(state_reg == ST_DATA) |->
    cnt_reg == $past(cycle_len))
    else $error("data phase length wrong");
  a_tag_abort: assert property ((state_reg == ST_TAG) && last &&
    (tag_par_bad || ctl_par_bad) |=> herr_reg && state_reg == ST_IDLE)
    else $error("tag parity error not aborted");
  a_tag_off: assert property ((state_reg == ST_EXT) ||
    (state_reg == ST_HOLD) |-> !tren_reg && !ctlwe_reg && !den_reg)
    else $error("tag enable during external or hold");
  a_enable_style: assert property ($rose(state_reg == ST_TAG) |->
    tren_reg != $past(enable_style_bit))
    else $error("tag enable style wrong");
  a_ctl_parity: assert property (ctlwe_reg |-> !(^ctl_reg) &&
    !ctloe_n_reg)
    else $error("state write parity wrong");
  a_hold_release: assert property ($rose(grant_reg) |->
    adr_oe_n_reg && doe_n_reg ##1 grant_reg || !$past(s_hold, 1))
    else $error("hold granted with buses driven");

  c_read_hit: cover property (rv_reg && rl_reg && !op_wr_reg);
  c_write_dirty: cover property (state_reg == ST_DIRTY);
  c_external: cover property ((state_reg == ST_EXT) ##1 rv_reg);
  c_hold: cover property (grant_reg ##1 !grant_reg);
endmodule // ectdi_top
`default_nettype wire

// ---- bench/ectdi_ram_model.sv ----
// Tag RAM, data RAM and system logic model for the cache sequencer bench
`timescale 1ns/10ps
`default_nettype none
module ectdi_ram_model
  import ectdi_pkg::*;
  (
  input wire logic core_clk,
  input wire logic [ADR_W-1:0] adr_in,
  input wire logic ext_tag_en,
  input wire logic bad_tag_par,
  input wire logic bad_ctl_par,
  input wire logic tag_ram_enable,
  input wire logic tag_ctl_write_enable,
  input wire logic [CTL_W-1:0] tag_ctl_out,
  input wire logic tag_ctl_oe_n,
  input wire logic data_ram_enable,
  input wire logic data_ram_write_enable,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic [CHK_W-1:0] check_out,
  input wire logic data_oe_n,
  input wire logic ext_cycle_req,
  input wire logic [3:0] ext_delay,
  output logic [TAG_W-1:0] tag_address_in,
  output logic tag_address_parity_in,
  output logic [CTL_W-1:0] tag_ctl_in,
  output logic [DATA_W-1:0] data_in,
  output logic [CHK_W-1:0] check_in,
  output logic ext_data_drive_enable_n,
  output logic ext_cycle_done
  );
  logic [TAG_W-1:0] tag_mem [16];
  logic [CTL_W-1:0] ctl_mem [16];
  logic [DATA_W-1:0] d_mem [16];
  logic [CHK_W-1:0] c_mem [16];
  // Unselected RAMs toggle so stale data never looks valid
  logic [DATA_W-1:0] junk_reg = {4{32'h5a5a_c3c3}};
  logic [3:0] ext_cnt_reg = 4'h0;
  logic [3:0] idx;
  logic tag_on;
  assign idx = adr_in[3:0];
  assign tag_on = tag_ram_enable | ext_tag_en;
  assign tag_address_in = tag_on ? tag_mem[idx] : junk_reg[TAG_W-1:0];
  assign tag_address_parity_in = tag_on ? ^tag_mem[idx] ^ bad_tag_par
    : junk_reg[20];
  assign tag_ctl_in = !tag_ctl_oe_n ? tag_ctl_out : tag_on
    ? ctl_mem[idx] ^ {3'h0, bad_ctl_par} : junk_reg[3:0];
  assign data_in = !data_oe_n ? data_out : data_ram_enable ? d_mem[idx]
    : junk_reg;
  assign check_in = !data_oe_n ? check_out : data_ram_enable ? c_mem[idx]
    : junk_reg[CHK_W-1:0];
  assign ext_cycle_done = ext_cycle_req && ext_cnt_reg >= ext_delay;
  assign ext_data_drive_enable_n = !(ext_cycle_req && ext_cnt_reg >= 4'h2);
  always @(posedge core_clk)
  begin
    junk_reg <= ~junk_reg;
    if (tag_ctl_write_enable && !tag_ctl_oe_n)
      ctl_mem[idx] <= tag_ctl_out;
    if (data_ram_write_enable && !data_oe_n)
    begin
      d_mem[idx] <= data_out;
      c_mem[idx] <= check_out;
    end
    // Saturates so a slow release never wraps the done flag low
    if (!ext_cycle_req)
      ext_cnt_reg <= 4'h0;
    else if (ext_cnt_reg != 4'hf)
      ext_cnt_reg <= ext_cnt_reg + 4'h1;
  end
endmodule // ectdi_ram_model
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the external cache tag and data sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import ectdi_pkg::*;
  ;
  typedef struct packed {
    logic loc, rd, herr, derr;
    logic [DATA_W-1:0] data;
  } ectdi_exp_t;
  logic core_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0;
  logic req_special = 1'b0, cache_enable_bit = 1'b1, ecc_select_bit = 1'b1;
  logic enable_style_bit = 1'b0, cache_hold_request = 1'b0;
  logic ext_tag_en = 1'b0, bad_tag_par = 1'b0, bad_ctl_par = 1'b0;
  logic [ADR_W-1:0] req_addr = '0, hold_adr = '0, adr_in, adr_out;
  logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, data_in, data_out;
  logic [SIZE_W-1:0] cache_size_field = 4'h0;
  logic [CLEN_W-1:0] cycle_len = 4'h4;
  logic [3:0] ext_delay = 4'h3;
  logic req_ready, rsp_valid, rsp_local, hard_error, data_error, adr_oe_n;
  logic tag_equal_n, data_oe_n, ext_data_drive_enable_n, tag_ram_enable;
  logic tag_address_parity_in, tag_ctl_write_enable, tag_ctl_oe_n;
  logic data_ram_enable, data_ram_write_enable, cache_hold_grant;
  logic ext_cycle_req, ext_cycle_done;
  logic [CHK_W-1:0] check_in, check_out;
  logic [TAG_W-1:0] tag_address_in;
  logic [CTL_W-1:0] tag_ctl_in, tag_ctl_out;
  logic [TAG_W-1:0] sh_tag [8];
  logic [2:0] sh_ctl [8];
  logic [DATA_W-1:0] sh_data [8];
  logic sh_bad [8];
  logic herr_seen = 1'b0, derr_seen = 1'b0, full_seen = 1'b0;
  ectdi_exp_t exp_q [$];
  ectdi_exp_t mon_e;
  integer seed = 35;
  int mismatches = 0;
  int checks_done = 0;

  assign adr_in = adr_oe_n ? hold_adr : adr_out;
  ectdi_top ectdi_top_inst (.*);
  ectdi_ram_model ectdi_ram_model_inst (.*);
  always #12.5 core_clk = ~core_clk;

  task automatic chk(input string what, input logic [DATA_W-1:0] exp_v,
                     input logic [DATA_W-1:0] got);
    checks_done++;
    if (exp_v !== got)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp_v, got);
    end
  endtask

  task automatic end_sim;
    if (mismatches == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic [CHK_W-1:0] tb_chk(input logic [DATA_W-1:0] d,
                                               input logic ecc);
    logic [CHK_W-1:0] c;
    logic [LW_W-1:0] w;
    c = '0;
    for (int n = 0; n < LW_N; n++)
    begin
      w = d[n*LW_W +: LW_W];
      for (int k = 0; k < ECC_W; k++)
        if (ecc)
          c[n*ECC_W+k] = ^(w & ECC_MASK[k]) ^ (k == XNOR_A || k == XNOR_B);
      if (!ecc)
        c[n*ECC_W] = ^w;
    end
    return c;
  endfunction

  task automatic load(input int i, input logic [2:0] st);
    sh_tag[i] = TAG_W'($random(seed));
    sh_ctl[i] = st;
    sh_data[i] = {$random(seed), $random(seed), $random(seed), $random(seed)};
    sh_bad[i] = (i == 7);
    ectdi_ram_model_inst.tag_mem[i] = sh_tag[i];
    ectdi_ram_model_inst.ctl_mem[i] = {st, ^st};
    ectdi_ram_model_inst.d_mem[i] = sh_data[i];
    ectdi_ram_model_inst.c_mem[i] = tb_chk(sh_data[i], 1'b1) ^ CHK_W'(i == 7);
  endtask

  // Called right after an edge; leaves the request up for chaining
  task automatic op(input logic wr, input logic sp, input int i,
                    input logic miss);
    ectdi_exp_t e;
    logic [DATA_W-1:0] w;
    w = {$random(seed), $random(seed), $random(seed), $random(seed)};
    e.herr = cache_enable_bit && (bad_tag_par || bad_ctl_par);
    e.loc = cache_enable_bit && sh_ctl[i][2] && !miss && !e.herr && !sp
      && !(wr && sh_ctl[i][1]);
    e.rd = e.loc && !wr;
    e.derr = e.rd && sh_bad[i];
    e.data = sh_data[i];
    if (e.loc && wr)
    begin
      sh_data[i] = w;
      sh_ctl[i][0] = 1'b1;
      sh_bad[i] = 1'b0;
    end
    req_valid <= 1'b1;
    req_write <= wr;
    req_special <= sp;
    req_addr <= {sh_tag[i] ^ TAG_W'(miss), 8'(i), 4'(i)};
    req_wdata <= w;
    do @(posedge core_clk); while (req_ready !== 1'b1);
    exp_q.push_back(e);
  endtask

  task automatic idle;
    req_valid <= 1'b0;
    while (exp_q.size() != 0)
      @(posedge core_clk);
    repeat (4) @(posedge core_clk);
  endtask

  task automatic wait_grant(input logic lvl);
    int n;
    n = 0;
    while (cache_hold_grant !== lvl && n < 60)
    begin
      @(posedge core_clk);
      n++;
    end
    chk("cache_hold_grant", lvl, cache_hold_grant);
    repeat (6) @(posedge core_clk);
  endtask

  always @(posedge core_clk)
  begin
    if (!rst)
    begin
      herr_seen = herr_seen | (hard_error === 1'b1);
      derr_seen = derr_seen | (data_error === 1'b1);
      if (req_valid === 1'b1 && req_ready === 1'b0 && exp_q.size() >= 8)
        full_seen = 1'b1;
      if (rsp_valid === 1'b1)
      begin
        if (exp_q.size() == 0)
          chk("rsp_valid", 1'b0, 1'b1);
        else
        begin
          mon_e = exp_q.pop_front();
          chk("rsp_local", mon_e.loc, rsp_local);
          if (mon_e.rd)
            chk("rsp_rdata", mon_e.data, rsp_rdata);
          chk("hard_error", mon_e.herr, herr_seen);
          chk("data_error", mon_e.derr, derr_seen);
        end
        herr_seen = 1'b0;
        derr_seen = 1'b0;
      end
      if (data_ram_write_enable === 1'b1 && data_oe_n === 1'b0)
        chk("check_out", tb_chk(data_out, ecc_select_bit), check_out);
      if (tag_ctl_write_enable === 1'b1 && tag_ctl_oe_n === 1'b0)
        chk("tag_ctl_out", 4'b1010, tag_ctl_out);
    end
  end

  initial
  begin
    #(25ns * 40000);
    mismatches++;
    end_sim;
  end

  initial
  begin
    for (int i = 0; i < 8; i++)
      load(i, 3'b100);
    load(1, 3'b101);
    load(2, 3'b110);
    load(3, 3'b000);
    cycle_len = CLEN_W'(4 + ($random(seed) & 3));
    enable_style_bit = 1'($random(seed));
    repeat (10) @(posedge core_clk);
    chk("adr_oe_n", 1'b1, adr_oe_n);
    chk("tag_ram_enable", 1'b0, tag_ram_enable);
    chk("data_oe_n", 1'b1, data_oe_n);
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    op(0, 0, 0, 0); op(1, 0, 0, 0); op(0, 0, 0, 0); op(1, 0, 2, 0);
    op(0, 0, 2, 0); op(0, 0, 3, 0); op(0, 0, 4, 1); op(0, 1, 4, 0);
    op(1, 1, 5, 0); op(1, 0, 1, 0); op(0, 0, 7, 0);
    idle;
    chk("req_ready_refused", 1'b1, full_seen);
    ecc_select_bit <= 1'b0;
    @(posedge core_clk);
    op(1, 0, 6, 0); op(0, 0, 6, 0);
    idle;
    ecc_select_bit <= 1'b1;
    // Rewrite the parity-coded block so later ECC reads stay clean
    op(1, 0, 6, 0);
    idle;
    bad_tag_par <= 1'b1;
    @(posedge core_clk);
    op(0, 0, 0, 0);
    idle;
    bad_tag_par <= 1'b0;
    bad_ctl_par <= 1'b1;
    @(posedge core_clk);
    op(1, 0, 5, 0);
    idle;
    bad_ctl_par <= 1'b0;
    cache_enable_bit <= 1'b0;
    @(posedge core_clk);
    op(0, 0, 0, 0); op(1, 0, 1, 0);
    idle;
    cache_enable_bit <= 1'b1;
    for (int n = 0; n < 16; n++)
    begin
      ext_delay <= 4'(2 + ($random(seed) & 7));
      op(1'($random(seed)), ($random(seed) & 7) == 0, $random(seed) & 7,
         ($random(seed) & 3) == 0);
    end
    idle;
    ext_tag_en <= 1'b1;
    hold_adr <= {sh_tag[2], 8'h00, 4'h2};
    cache_hold_request <= 1'b1;
    wait_grant(1'b1);
    chk("adr_oe_n", 1'b1, adr_oe_n);
    chk("tag_ram_enable", 1'b0, tag_ram_enable);
    chk("tag_equal_n", 1'b0, tag_equal_n);
    hold_adr <= hold_adr ^ (ADR_W'(1) << 12);
    repeat (6) @(posedge core_clk);
    chk("tag_equal_n", 1'b1, tag_equal_n);
    cache_size_field <= 4'h1;
    repeat (6) @(posedge core_clk);
    chk("tag_equal_n", 1'b0, tag_equal_n);
    cache_size_field <= 4'h0;
    cache_hold_request <= 1'b0;
    ext_tag_en <= 1'b0;
    wait_grant(1'b0);
    chk("adr_oe_n", 1'b0, adr_oe_n);
    op(0, 0, 0, 0);
    idle;
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
